// ===== rtl/rgn_pkg.sv
// region access-mode checker: shared constants, modes, codes, map
// assumes a 32-bit address space and 4-bit region mode codes
package rgn_pkg;

   localparam int RGN_ADDR_W   = 32;
   localparam int RGN_NUM      = 8;
   localparam int RGN_SEL_W    = 3;
   localparam int RGN_SEL_LSB  = 29;  // regions step by 0x2000_0000
   localparam int RGN_MODE_W   = 4;

   // mode codes
   localparam logic [3:0] RGN_M_NOALLOC = 4'h0;
   localparam logic [3:0] RGN_M_WTHRU   = 4'h1;
   localparam logic [3:0] RGN_M_BYPASS  = 4'h2;
   localparam logic [3:0] RGN_M_UNSUP   = 4'h3;
   localparam logic [3:0] RGN_M_WBACK   = 4'h4;
   localparam logic [3:0] RGN_M_RSV_LO  = 4'h5;
   localparam logic [3:0] RGN_M_RSV_HI  = 4'hd;
   localparam logic [3:0] RGN_M_ISOLATE = 4'he;
   localparam logic [3:0] RGN_M_ILLEGAL = 4'hf;

   // mode of every region after reset
   localparam logic [3:0] RGN_MODE_RST  = RGN_M_BYPASS;

   // exception cause codes presented to the pipeline
   localparam logic [1:0] RGN_CAUSE_NONE  = 2'h0;
   localparam logic [1:0] RGN_CAUSE_FETCH = 2'h1;  // fetch_prohibited_cause
   localparam logic [1:0] RGN_CAUSE_LOAD  = 2'h2;  // load_prohibited_cause_a
   localparam logic [1:0] RGN_CAUSE_STORE = 2'h3;  // store_prohibited_cause_b

   // access kinds
   typedef enum logic [1:0] {
      RGN_ACC_FETCH = 2'h0,
      RGN_ACC_LOAD  = 2'h1,
      RGN_ACC_STORE = 2'h2
   } rgn_acc_e;

   // cache handling selected for an access
   typedef enum logic [5:0] {
      RGN_H_NONE    = 6'h01,
      RGN_H_NOALLOC = 6'h02,
      RGN_H_ALLOC   = 6'h04,
      RGN_H_WTHRU   = 6'h08,
      RGN_H_WBACK   = 6'h10,
      RGN_H_ISOLATE = 6'h20
   } rgn_hdl_e;

   // apb map of the block's own registers
   localparam logic [11:0] RGN_OFS_IMODE  = 12'h000;
   localparam logic [11:0] RGN_OFS_DMODE  = 12'h004;
   localparam logic [11:0] RGN_OFS_STAT   = 12'h008;
   localparam logic [11:0] RGN_OFS_CLR    = 12'h00c;
   localparam logic [11:0] RGN_OFS_EN     = 12'h010;
   localparam logic [11:0] RGN_OFS_LAST   = 12'h014;
   localparam logic [31:0] RGN_MODES_RST  = {8{RGN_MODE_RST}};

   localparam int RGN_EV_W     = 3;
   localparam int RGN_EV_FETCH = 0;
   localparam int RGN_EV_LOAD  = 1;
   localparam int RGN_EV_STORE = 2;

   function automatic logic [2:0] rgn_region(input logic [31:0] addr);
      rgn_region = addr[RGN_SEL_LSB +: RGN_SEL_W];
   endfunction : rgn_region

endpackage : rgn_pkg

// ===== rtl/rgn_mode_if.sv
// region access-mode checker: mode table to decoder carrier
// assumes one clock; table and decoder live in the same top
`timescale 1ns/1ps
interface rgn_mode_if;
   logic [31:0] imodes;  // packed 8 x 4-bit fetch-side modes
   logic [31:0] dmodes;  // packed 8 x 4-bit data-side modes
   modport table_end (output imodes, output dmodes);
   modport check_end (input imodes, input dmodes);
endinterface : rgn_mode_if

// ===== rtl/rgn_mode_table.sv
// region access-mode checker: per-region mode storage
// assumes writes come from the pipeline's mode-write instructions or apb
`timescale 1ns/1ps
module rgn_mode_table
   import rgn_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        wr_inst,
   input  wire logic        wr_data,
   input  wire logic [2:0]  wr_region,
   input  wire logic [3:0]  wr_mode,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_wr_d,
   input  wire logic [31:0] bus_wdata,
   rgn_mode_if.table_end    tbl
);
   import rgn_pkg::*;

   logic [31:0] imodes;
   logic [31:0] dmodes;
   logic [31:0] next_imodes;
   logic [31:0] next_dmodes;

   // pipeline instruction wins over a same-cycle bus write
   always_comb begin
      next_imodes = bus_wr_i ? bus_wdata : imodes;
      next_dmodes = bus_wr_d ? bus_wdata : dmodes;
      if (wr_inst) begin
         next_imodes[wr_region*RGN_MODE_W +: RGN_MODE_W] = wr_mode;
      end
      if (wr_data) begin
         next_dmodes[wr_region*RGN_MODE_W +: RGN_MODE_W] = wr_mode;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         imodes <= RGN_MODES_RST;
         dmodes <= RGN_MODES_RST;
      end else begin
         imodes <= next_imodes;
         dmodes <= next_dmodes;
      end
   end

   assign tbl.imodes = imodes;
   assign tbl.dmodes = dmodes;

   AST_INST_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
      wr_inst |=> imodes[$past(wr_region)*4 +: 4] == $past(wr_mode))
      else $error("fetch-side mode not updated");
   AST_DATA_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
      wr_data |=> dmodes[$past(wr_region)*4 +: 4] == $past(wr_mode))
      else $error("data-side mode not updated");

endmodule : rgn_mode_table

// ===== rtl/rgn_checker.sv
// region access-mode checker: top, decode, apb slave and interrupt
// assumes the pipeline holds acc_valid until acc_ready; one clock
// Function
// - eight equal regions chosen by address bits 31..29, 512 MB apart.
// - separate mode per region for fetches and for loads/stores.
// - fetch-side or data-side mode write instruction updates that region.
// - mode 0000: fetch faults, loads no-allocate, stores write-through.
// - no-allocate: a cache hit returns the cached value.
// - no-allocate: allocated line lacking data is filled from memory.
// - mode 0001: allocate on fetch/load, stores write-through no allocate.
// - mode 0010: all accesses bypass the cache to memory.
// - uncached regions are never cached; accesses reach the target.
// - mode 0100: write-back allocate if option present, else write-through.
// - mode 1110: fetch faults, loads/stores access cache arrays directly.
// - isolate gives loads/stores direct cache storage access, no tags.
// - modes 0101..1101 raise fetch, load or store prohibited faults.
// - mode 1111 blocks all accesses with the matching fault.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module rgn_checker
   import rgn_pkg::*;
#(
   parameter bit WB_OPTION = 1'b1
)(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // access request from the pipeline
   input  wire logic        acc_valid,
   input  wire logic [1:0]  acc_kind,
   input  wire logic [31:0] acc_addr,
   output logic             acc_ready,
   // decision, one cycle after the request
   output logic             res_valid,
   output logic [5:0]       res_handling,
   output logic [1:0]       res_cause,
   output logic             res_use_cache,
   output logic             res_allocate,
   output logic             res_mem_write,
   output logic             res_fill_line,
   // cache state for the requested line
   input  wire logic        cache_hit,
   input  wire logic        line_alloc,
   // mode-write instructions
   input  wire logic        write_inst_region_mode,
   input  wire logic        write_data_region_mode,
   input  wire logic [31:0] wr_addr,
   input  wire logic [3:0]  wr_mode,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   import rgn_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // mode table

   rgn_mode_if mif ();
   logic apb_wr;
   // write lands only at the edge that completes the transfer
   assign apb_wr = psel && penable && pwrite && pready;

   rgn_mode_table u_tbl (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .wr_inst   (write_inst_region_mode),
      .wr_data   (write_data_region_mode),
      .wr_region (rgn_region(wr_addr)),
      .wr_mode   (wr_mode),
      .bus_wr_i  (apb_wr && paddr == RGN_OFS_IMODE),
      .bus_wr_d  (apb_wr && paddr == RGN_OFS_DMODE),
      .bus_wdata (pwdata),
      .tbl       (mif.table_end)
   );

   ////////////////////////////////////////////////////////////////////
   // decode of one access

   logic [2:0] region;
   logic [3:0] mode;
   rgn_hdl_e   hdl;
   logic [1:0] cause;
   logic       use_cache;
   logic       alloc;
   logic       mem_wr;
   logic       fill;
   logic       is_fetch;
   logic       is_store;

   assign region   = rgn_region(acc_addr);
   assign is_fetch = acc_kind == RGN_ACC_FETCH;
   assign is_store = acc_kind == RGN_ACC_STORE;
   // separate sets for fetch and data side
   assign mode = is_fetch ? mif.imodes[region*4 +: 4]
                          : mif.dmodes[region*4 +: 4];

   function automatic logic [1:0] fault(input logic [1:0] k);
      case (k)
         RGN_ACC_FETCH: fault = RGN_CAUSE_FETCH;
         RGN_ACC_LOAD:  fault = RGN_CAUSE_LOAD;
         default:       fault = RGN_CAUSE_STORE;
      endcase
   endfunction : fault

   always_comb begin
      hdl       = RGN_H_NONE;
      cause     = RGN_CAUSE_NONE;
      use_cache = 1'b0;
      alloc     = 1'b0;
      mem_wr    = 1'b0;
      fill      = 1'b0;
      case (mode)
         RGN_M_NOALLOC: begin
            if (is_fetch) begin
               cause = RGN_CAUSE_FETCH;
            end else if (is_store) begin
               hdl       = RGN_H_WTHRU;
               use_cache = cache_hit;
               mem_wr    = 1'b1;
            end else begin
               hdl       = RGN_H_NOALLOC;
               use_cache = cache_hit;
               fill      = !cache_hit && line_alloc;
            end
         end
         RGN_M_WTHRU: begin
            if (is_store) begin
               hdl       = RGN_H_WTHRU;
               use_cache = cache_hit;
               mem_wr    = 1'b1;
            end else begin
               hdl       = RGN_H_ALLOC;
               use_cache = 1'b1;
               alloc     = !cache_hit;
            end
         end
         RGN_M_BYPASS: begin
            // cache untouched so device registers always see the access
            hdl    = RGN_H_NONE;
            mem_wr = is_store;
         end
         RGN_M_WBACK: begin
            if (is_store && !WB_OPTION) begin
               hdl       = RGN_H_WTHRU;
               use_cache = cache_hit;
               mem_wr    = 1'b1;
            end else begin
               // dirty data leaves only on eviction or forced writeback
               if (is_store) begin
                  hdl = RGN_H_WBACK;
               end else begin
                  hdl = RGN_H_ALLOC;
               end
               use_cache = 1'b1;
               alloc     = !cache_hit;
            end
         end
         RGN_M_ISOLATE: begin
            if (is_fetch) begin
               cause = RGN_CAUSE_FETCH;
            end else begin
               hdl       = RGN_H_ISOLATE;
               use_cache = 1'b1;
            end
         end
         RGN_M_UNSUP: begin
            cause = fault(acc_kind);
         end
         RGN_M_ILLEGAL: begin
            cause = fault(acc_kind);
         end
         default: begin
            cause = fault(acc_kind);
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // registered result

   logic       next_res_valid;
   logic       take;
   assign take           = acc_valid && acc_ready;
   assign next_res_valid = take;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_ready     <= 1'b0;
         res_valid     <= 1'b0;
         res_handling  <= RGN_H_NONE;
         res_cause     <= RGN_CAUSE_NONE;
         res_use_cache <= 1'b0;
         res_allocate  <= 1'b0;
         res_mem_write <= 1'b0;
         res_fill_line <= 1'b0;
      end else begin
         acc_ready     <= 1'b1;
         res_valid     <= next_res_valid;
         res_handling  <= take ? hdl : RGN_H_NONE;
         res_cause     <= take ? cause : RGN_CAUSE_NONE;
         res_use_cache <= take && use_cache;
         res_allocate  <= take && alloc;
         res_mem_write <= take && mem_wr;
         res_fill_line <= take && fill;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fault status, enable, last fault, apb

   logic [2:0]  stat;
   logic [2:0]  en;
   logic [31:0] last;
   logic [2:0]  next_stat;
   logic [2:0]  next_en;
   logic [31:0] next_last;
   logic [2:0]  ev;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        mapped;

   always_comb begin
      ev = 3'h0;
      if (take && cause != RGN_CAUSE_NONE) begin
         ev[cause - 2'h1] = 1'b1;
      end
      // set beats a same-cycle clear
      next_stat = stat;
      if (apb_wr && paddr == RGN_OFS_CLR) begin
         next_stat = stat & ~pwdata[2:0];
      end
      next_stat = next_stat | ev;
      next_en   = (apb_wr && paddr == RGN_OFS_EN) ? pwdata[2:0] : en;
      next_last = (ev != 3'h0) ? acc_addr : last;
      mapped    = paddr <= RGN_OFS_LAST && paddr[1:0] == 2'h0;
      case (paddr)
         RGN_OFS_IMODE: next_prdata = mif.imodes;
         RGN_OFS_DMODE: next_prdata = mif.dmodes;
         RGN_OFS_STAT:  next_prdata = {29'h0, stat};
         RGN_OFS_EN:    next_prdata = {29'h0, en};
         RGN_OFS_LAST:  next_prdata = last;
         default:       next_prdata = 32'h0;
      endcase
      // one wait state: ready comes in the second access cycle
      next_pready  = psel && penable && !pready;
      next_pslverr = psel && penable && !pready && !mapped;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat    <= 3'h0;
         en      <= 3'h0;
         last    <= 32'h0;
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         stat    <= next_stat;
         en      <= next_en;
         last    <= next_last;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         irq     <= |(next_stat & next_en);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   AST_BYPASS_NO_CACHE: assert property (@(posedge clk_sys) disable iff (rst)
      take && mode == RGN_M_BYPASS |=> !res_use_cache && !res_allocate
         && res_cause == RGN_CAUSE_NONE)
      else $error("bypass touched the cache");
   AST_ILLEGAL_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
      take && mode == RGN_M_ILLEGAL |=> res_valid
         && res_cause == $past(acc_kind) + 2'h1)
      else $error("illegal mode did not fault");
   AST_RESERVED_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
      take && mode >= RGN_M_RSV_LO && mode <= RGN_M_RSV_HI
      |=> res_cause == $past(acc_kind) + 2'h1)
      else $error("reserved mode did not fault");
   AST_UNSUP_FAULT: assert property (@(posedge clk_sys) disable iff (rst)
      take && mode == RGN_M_UNSUP |=> res_cause != RGN_CAUSE_NONE)
      else $error("mode 0011 did not fault");
   AST_NOALLOC_FETCH: assert property (@(posedge clk_sys) disable iff (rst)
      take && is_fetch && (mode == RGN_M_NOALLOC || mode == RGN_M_ISOLATE)
      |=> res_cause == RGN_CAUSE_FETCH)
      else $error("fetch not prohibited");
   AST_NOALLOC_HIT: assert property (@(posedge clk_sys) disable iff (rst)
      take && mode == RGN_M_NOALLOC && acc_kind == RGN_ACC_LOAD
      |=> !res_allocate && res_use_cache == $past(cache_hit)
         && res_fill_line == ($past(line_alloc) && !$past(cache_hit)))
      else $error("no-allocate load misbehaved");
   AST_WTHRU_STORE: assert property (@(posedge clk_sys) disable iff (rst)
      take && is_store && mode == RGN_M_WTHRU
      |=> res_mem_write && !res_allocate)
      else $error("write-through store wrong");
   AST_WBACK_STORE: assert property (@(posedge clk_sys) disable iff (rst)
      take && is_store && mode == RGN_M_WBACK
      |=> res_mem_write == !WB_OPTION)
      else $error("write-back store wrong");
   AST_ISOLATE_DIRECT: assert property (@(posedge clk_sys) disable iff (rst)
      take && !is_fetch && mode == RGN_M_ISOLATE
      |=> res_handling == RGN_H_ISOLATE && !res_mem_write)
      else $error("isolate not direct");

endmodule : rgn_checker

// ===== sim/rgn_cache_model.sv
// cache lookup model standing in for the pipeline's cache controller
// assumes the bench encodes the line state in address bits 5:4
`timescale 1ns/1ps
module rgn_cache_model (
   input  wire logic [31:0] acc_addr,
   output logic             cache_hit,
   output logic             line_alloc
);
   // a hit always implies an allocated line, as in a real cache
   assign cache_hit  = acc_addr[4];
   assign line_alloc = acc_addr[5] | acc_addr[4];
endmodule : rgn_cache_model

// ===== sim/tb_top.sv
// self-checking bench for the region access-mode checker
// assumes one clock; bench drives access, mode-write and apb ports
`timescale 1ns/1ps
module tb_top;
   import rgn_pkg::*;
   typedef struct packed {
      logic [1:0] kind;
      logic [3:0] mode;
      logic       hit;
      logic       al;
      logic [5:0] hdl;
      logic [1:0] cause;
      logic [3:0] flg;
      logic [3:0] care;
   } rgn_row_s;
   localparam logic [1:0] FE = RGN_ACC_FETCH;
   localparam logic [1:0] LD = RGN_ACC_LOAD;
   localparam logic [1:0] ST = RGN_ACC_STORE;
   localparam logic [1:0] CN = RGN_CAUSE_NONE;
   localparam logic [1:0] CF = RGN_CAUSE_FETCH;
   localparam logic [1:0] CL = RGN_CAUSE_LOAD;
   localparam logic [1:0] CS = RGN_CAUSE_STORE;
   localparam logic       N  = 1'b0;
   localparam logic       Y  = 1'b1;
   logic        clk_sys, rst, acc_valid, acc_ready, res_valid, irq;
   logic [1:0]  acc_kind, res_cause, s_cause;
   logic [31:0] acc_addr, wr_addr, pwdata, prdata, rd;
   logic [5:0]  res_handling, s_hdl;
   logic        res_use_cache, res_allocate, res_mem_write, res_fill_line;
   logic        cache_hit, line_alloc, s_vld, er;
   logic        write_inst_region_mode, write_data_region_mode;
   logic [3:0]  wr_mode, s_flg;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   int          n_errors, checked;
   rgn_row_s    r;
   // flags are {use_cache, allocate, mem_write, fill_line}; care masks
   rgn_row_s    rows [20] = '{
      '{FE,4'h0,N,N,RGN_H_NONE,CF,4'h0,4'hf},
      '{LD,4'h0,Y,Y,RGN_H_NOALLOC,CN,4'h8,4'hf},
      '{LD,4'h0,N,Y,RGN_H_NOALLOC,CN,4'h1,4'h7},
      '{LD,4'h0,N,N,RGN_H_NOALLOC,CN,4'h0,4'h7},
      '{ST,4'h0,Y,Y,RGN_H_WTHRU,CN,4'ha,4'he},
      '{FE,4'h1,N,N,RGN_H_ALLOC,CN,4'hc,4'he},
      '{LD,4'h1,Y,Y,RGN_H_ALLOC,CN,4'h8,4'he},
      '{ST,4'h1,N,N,RGN_H_WTHRU,CN,4'h2,4'h6},
      '{FE,4'h2,Y,Y,RGN_H_NONE,CN,4'h0,4'hf},
      '{LD,4'h2,Y,Y,RGN_H_NONE,CN,4'h0,4'hf},
      '{ST,4'h2,Y,Y,RGN_H_NONE,CN,4'h2,4'hf},
      '{FE,4'h3,N,N,RGN_H_NONE,CF,4'h0,4'hf},
      '{LD,4'h3,N,N,RGN_H_NONE,CL,4'h0,4'hf},
      '{ST,4'h3,N,N,RGN_H_NONE,CS,4'h0,4'hf},
      '{FE,4'h4,N,N,RGN_H_ALLOC,CN,4'hc,4'he},
      '{ST,4'h4,N,N,RGN_H_WBACK,CN,4'hc,4'he},
      '{ST,4'h4,Y,Y,RGN_H_WBACK,CN,4'h0,4'h6},
      '{FE,4'he,N,N,RGN_H_NONE,CF,4'h0,4'hf},
      '{LD,4'he,Y,Y,RGN_H_ISOLATE,CN,4'h8,4'hf},
      '{ST,4'he,N,N,RGN_H_ISOLATE,CN,4'h8,4'hf}};

   rgn_checker #(.WB_OPTION(1'b1)) dut_u (
      .clk_sys, .rst, .acc_valid, .acc_kind, .acc_addr, .acc_ready,
      .res_valid, .res_handling, .res_cause, .res_use_cache,
      .res_allocate, .res_mem_write, .res_fill_line, .cache_hit,
      .line_alloc, .write_inst_region_mode, .write_data_region_mode,
      .wr_addr, .wr_mode, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq);

   rgn_cache_model cache_u (.acc_addr, .cache_hit, .line_alloc);

   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   task automatic do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : do_reset

   // request held until the edge that takes it; the one-cycle result
   // is read at the following edge, before that edge updates it
   task automatic access(input logic [1:0] k, input logic [31:0] a);
      acc_valid <= 1'b1;
      acc_kind  <= k;
      acc_addr  <= a;
      do @(posedge clk_sys); while (acc_ready !== 1'b1);
      acc_valid <= 1'b0;
      @(posedge clk_sys);
      s_vld   = res_valid;
      s_hdl   = res_handling;
      s_cause = res_cause;
      s_flg   = {res_use_cache, res_allocate, res_mem_write, res_fill_line};
   endtask : access

   task automatic wmode(input logic ds, input logic [2:0] rg,
                        input logic [3:0] m);
      write_inst_region_mode <= !ds;
      write_data_region_mode <= ds;
      wr_addr                <= {rg, 29'h0};
      wr_mode                <= m;
      @(posedge clk_sys);
      write_inst_region_mode <= 1'b0;
      write_data_region_mode <= 1'b0;
   endtask : wmode

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives psel at once
      @(posedge clk_sys);
   endtask : apb

   ////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      n_errors++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      {acc_valid, acc_kind, acc_addr, wr_addr, wr_mode} = '0;
      {write_inst_region_mode, write_data_region_mode} = '0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      do_reset();
      chk("irq_rst", 32'(irq), 32'h0);
      apb(1'b0, RGN_OFS_DMODE, 32'h0);
      chk("dmode_rst", rd, RGN_MODES_RST);
      // data side of region 3 only: fetches there must stay legal
      wmode(1'b1, 3'h3, RGN_M_ILLEGAL);
      access(LD, 32'h5fff_fffc);
      chk("below_edge", 32'(s_cause), 32'(CN));
      access(LD, 32'h6000_0000);
      chk("at_edge", 32'(s_cause), 32'(CL));
      access(FE, 32'h7fff_fffc);
      chk("inst_side", 32'(s_cause), 32'(CN));
      for (int i = 0; i < 20; i++) begin
         r = rows[i];
         wmode(r.kind != FE, i[2:0], r.mode);
         access(r.kind, {i[2:0], 23'h0, r.al, r.hit, 4'h0});
         chk("valid", 32'(s_vld), 32'h1);
         chk("handling", 32'(s_hdl), 32'(r.hdl));
         chk("cause", 32'(s_cause), 32'(r.cause));
         chk("flags", 32'(s_flg & r.care), 32'(r.flg & r.care));
      end
      for (int m = 5; m < 16; m++) begin
         for (int k = 0; k < 3; k++) begin
            if (m != 14) begin
               wmode(k != 0, 3'h5, m[3:0]);
               access(k[1:0], 32'ha000_0040);
               chk("rsv_hdl", 32'(s_hdl), 32'(RGN_H_NONE));
               chk("rsv_cause", 32'(s_cause), k + 1);
               chk("rsv_flags", 32'(s_flg), 32'h0);
            end
         end
      end
      // region 5 is now fully blocked; use it as the fault source
      apb(1'b1, RGN_OFS_CLR, 32'h7);
      apb(1'b1, RGN_OFS_EN, 32'h7);
      chk("irq_clr", 32'(irq), 32'h0);
      access(ST, 32'ha000_0040);
      apb(1'b0, RGN_OFS_STAT, 32'h0);
      chk("stat", rd, 32'h4);
      chk("irq_set", 32'(irq), 32'h1);
      apb(1'b0, RGN_OFS_LAST, 32'h0);
      chk("last", rd, 32'ha000_0040);
      apb(1'b1, RGN_OFS_EN, 32'h0);
      chk("irq_mask", 32'(irq), 32'h0);
      apb(1'b1, RGN_OFS_EN, 32'h4);
      chk("irq_unmask", 32'(irq), 32'h1);
      apb(1'b1, RGN_OFS_CLR, 32'h4);
      chk("irq_w1c", 32'(irq), 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped_err", 32'(er), 32'h1);
      chk("unmapped_rd", rd, 32'h0);
      apb(1'b1, RGN_OFS_IMODE, 32'h2222_2221);
      access(FE, 32'h0000_0000);
      chk("apb_mode", 32'(s_hdl), 32'(RGN_H_ALLOC));
      // mid-run reset must bring every region back to bypass
      do_reset();
      apb(1'b0, RGN_OFS_IMODE, 32'h0);
      chk("imode_rst", rd, RGN_MODES_RST);
      access(FE, 32'he000_0000);
      chk("rst_bypass", 32'(s_hdl), 32'(RGN_H_NONE));
      wrap_up();
   end
endmodule : tb_top
